// ==== sysctl_params.svh ====
`ifndef SYSCTL_PARAMS_SVH
`define SYSCTL_PARAMS_SVH

// register byte offsets
`define OFS_SYSCTL 4'h0
`define OFS_EVT_STAT 4'h4
`define OFS_EVT_CLR 4'h8
`define OFS_EVT_EN 4'hC

// system control field positions
`define B_WATCH_EN 18
`define B_WATCH_HI 17
`define B_WATCH_LO 16
`define B_USER_OK 15
`define B_STRAP 14
`define B_DIAG 12
`define B_LEGACY 11
`define B_UNALIGN 10
`define B_HOLD 7
`define B_DMA_SOFT_RESET 6
`define CTL_WMASK 32'h0007_dcc0

// event bit positions
`define EV_TIMEOUT 0
`define EV_USER 1
`define EV_UNALIGN 2
`define EV_W 3

// bus watch periods in bus clocks
`define WATCH_P0 8'h80
`define WATCH_P1 8'h40
`define WATCH_P2 8'h20
`define WATCH_P3 8'h10

// access sizes
`define SZ_HALF 2'h1
`define SZ_WORD 2'h2

// reset values and the count step
`define ZERO32 32'h0000_0000
`define ZERO8 8'h00
`define ONE8 8'h01

`endif

// ==== sysctl_pkg.sv ====
package sysctl_pkg;

    // one bus cycle seen by the guard, valid while start is high
    typedef struct packed {
        logic start;
        logic user;
        logic int_reg;
        logic dma_ctx;
        logic [1:0] size;
        logic [1:0] addr_lo;
    } sys_req_t;

    // guard outputs towards the bus masters and subsystems
    typedef struct packed {
        logic data_abort;
        logic cycle_end;
        logic ctx_grant;
    } sys_rsp_t;

    typedef enum logic [1:0] {
        W_IDLE = 2'b01,
        W_WAIT = 2'b10
    } watch_st_t;

endpackage

// ==== system_control_guard.sv ====
// Local design decisions: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "sysctl_params.svh"

// What this block does
// [R1] The bus watch limit codes 0..3 pick 128, 64, 32 or 16 bus clocks.
// [R2] Software sets the limit longer than its slowest peripheral access.
// [R3] With monitoring on, an unacknowledged cycle ends with a data abort.
// [R4] User-mode register access aborts while the user access bit is 0.
// [R5] With the user access bit at 1 no mode is refused.
// [R6] The core enable strap loads the inverse of the strap line at reset.
// [R7] Software only ever writes 0 to the core enable strap bit.
// [R8] DMA diag mode holds the DMA subsystem reset and opens context memory.
// [R9] Without diag mode the DMA runs and context memory stays closed.
// [R10] The legacy termination bit is stored and read back, nothing else.
// [R11] The unaligned abort enable makes misaligned transfers abort.
// [R12] Odd halfword and non-word-aligned word accesses are misaligned.
// [R13] The core hold bit keeps the processor core in reset while set.
// [R14] The core hold bit loads the inverse of the strap line at reset.
// [R15] The DMA soft reset bit resets only the DMA module, default 0.
// [R16] The watch count restarts each cycle and steps once per bus clock.
// [R17] Reserved bits 13, 9 and 8 read as zero and ignore writes.
module system_control_guard
    import sysctl_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire sys_req_t sys_req,
    input wire logic transfer_ack_n,
    input wire logic boot_strap_line,
    output sys_rsp_t sys_rsp,
    output logic core_reset,
    output logic dma_sub_reset,
    output logic dma_mod_reset,
    output logic irq
);

    logic [31:0] ctl_ff;
    logic [31:0] nxt_ctl;
    logic strap_done_ff;
    logic [`EV_W-1:0] stat_ff;
    logic [`EV_W-1:0] en_ff;
    logic [`EV_W-1:0] nxt_stat;
    logic [`EV_W-1:0] nxt_en;
    logic [`EV_W-1:0] evt;
    logic wr_ff;
    logic [3:0] wa_ff;
    logic [31:0] hrdata_ff;
    logic hreadyout_ff;
    logic hresp_ff;
    watch_st_t st_ff;
    watch_st_t nxt_st;
    logic [7:0] cnt_ff;
    logic [7:0] nxt_cnt;
    sys_rsp_t rsp_ff;
    sys_rsp_t nxt_rsp;
    logic core_reset_ff;
    logic dma_sub_ff;
    logic dma_mod_ff;
    logic irq_ff;

    // bus decode
    wire addr_ph = hsel & hready & htrans[1];
    wire [3:0] a_lo = haddr[3:0];
    wire [31:0] wmask = `CTL_WMASK; // writable bits only
    wire wr_ctl = wr_ff & (wa_ff == `OFS_SYSCTL);
    wire wr_clr = wr_ff & (wa_ff == `OFS_EVT_CLR);
    wire wr_en = wr_ff & (wa_ff == `OFS_EVT_EN);

    // control fields
    wire [1:0] watch_sel = ctl_ff[`B_WATCH_HI:`B_WATCH_LO];
    wire watch_on = ctl_ff[`B_WATCH_EN];
    wire user_ok = ctl_ff[`B_USER_OK];
    wire diag = ctl_ff[`B_DIAG];
    wire unalign_en = ctl_ff[`B_UNALIGN];

    // watch period lookup
    wire [7:0] period = (watch_sel == 2'h0) ? `WATCH_P0 :
                        (watch_sel == 2'h1) ? `WATCH_P1 :
                        (watch_sel == 2'h2) ? `WATCH_P2 :
                        `WATCH_P3; // see [R1]
    wire [7:0] last_cnt = period - `ONE8;

    // misaligned cycle detect
    wire mis_half = (sys_req.size == `SZ_HALF) & sys_req.addr_lo[0];
    wire mis_word = (sys_req.size == `SZ_WORD) & (|sys_req.addr_lo);
    wire misaligned = mis_half | mis_word; // see [R12]

    // immediate refusals at cycle start
    wire user_abort = sys_req.start & sys_req.user & sys_req.int_reg
                      & ~user_ok; // see [R4] see [R5]
    wire unal_abort = sys_req.start & misaligned & unalign_en; // see [R11]
    wire refused = user_abort | unal_abort;
    wire watch_go = sys_req.start & ~refused & watch_on;
    wire acked = ~transfer_ack_n;
    // >= so a limit lowered mid-count still ends the cycle
    wire expire = (st_ff == W_WAIT) & ~acked
                  & (cnt_ff >= last_cnt); // see [R3]

    // read mux, reserved and unmapped read zero
    wire [31:0] rd_ctl = ctl_ff & wmask; // see [R17]
    wire [31:0] rd_stat = {29'h0, stat_ff};
    wire [31:0] rd_en = {29'h0, en_ff};
    wire [31:0] rd_val = (a_lo == `OFS_SYSCTL) ? rd_ctl :
                         (a_lo == `OFS_EVT_STAT) ? rd_stat :
                         (a_lo == `OFS_EVT_EN) ? rd_en : `ZERO32;

    // control register next value, strap capture wins on first edge
    always_comb begin
        nxt_ctl = ctl_ff;
        if (wr_ctl) begin
            nxt_ctl = (hwdata & wmask) | (ctl_ff & ~wmask); // see [R10]
        end
        if (!strap_done_ff) begin
            nxt_ctl[`B_STRAP] = ~boot_strap_line; // see [R6]
            nxt_ctl[`B_HOLD] = ~boot_strap_line; // see [R14]
        end
    end

    // events: set beats a same-cycle clear
    assign evt[`EV_TIMEOUT] = expire;
    assign evt[`EV_USER] = user_abort;
    assign evt[`EV_UNALIGN] = unal_abort;
    assign nxt_stat = (stat_ff & ~(wr_clr ? hwdata[`EV_W-1:0] : 3'h0))
                      | evt;
    assign nxt_en = wr_en ? hwdata[`EV_W-1:0] : en_ff;

    // watch machine, restart per cycle and count per clock
    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        unique case (st_ff)
            W_IDLE: begin
                if (watch_go) begin
                    nxt_st = W_WAIT;
                    nxt_cnt = `ZERO8; // see [R16]
                end
            end
            W_WAIT: begin
                if (acked || expire) begin
                    nxt_st = W_IDLE;
                end else begin
                    nxt_cnt = cnt_ff + `ONE8; // see [R16]
                end
            end
            default: begin
                nxt_st = W_IDLE;
            end
        endcase
    end

    // responses to the cycle owner
    assign nxt_rsp.data_abort = refused | expire; // see [R3]
    assign nxt_rsp.cycle_end = expire;
    assign nxt_rsp.ctx_grant = sys_req.start & sys_req.dma_ctx
                               & diag; // see [R8] see [R9]

    // control register and strap capture
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_ff <= `ZERO32;
            strap_done_ff <= 1'b0;
        end else begin
            ctl_ff <= nxt_ctl;
            strap_done_ff <= 1'b1;
        end
    end

    // event status and enable
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_ff <= 3'h0;
            en_ff <= 3'h0;
            irq_ff <= 1'b0;
        end else begin
            stat_ff <= nxt_stat;
            en_ff <= nxt_en;
            irq_ff <= |(nxt_stat & nxt_en);
        end
    end

    // bus slave, zero wait states, always okay
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ff <= 1'b0;
            wa_ff <= 4'h0;
            hrdata_ff <= `ZERO32;
            hreadyout_ff <= 1'b1;
            hresp_ff <= 1'b0;
        end else begin
            wr_ff <= addr_ph & hwrite;
            wa_ff <= a_lo;
            hrdata_ff <= (addr_ph & ~hwrite) ? rd_val : `ZERO32;
        end
    end

    // watch counter
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= W_IDLE;
            cnt_ff <= `ZERO8;
        end else begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
        end
    end

    // registered outputs; resets follow the control bits
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_ff <= '0;
            core_reset_ff <= 1'b0;
            dma_sub_ff <= 1'b0;
            dma_mod_ff <= 1'b0;
        end else begin
            rsp_ff <= nxt_rsp;
            core_reset_ff <= nxt_ctl[`B_HOLD]; // see [R13]
            dma_sub_ff <= nxt_ctl[`B_DIAG]; // see [R8]
            dma_mod_ff <= nxt_ctl[`B_DMA_SOFT_RESET]; // see [R15]
        end
    end

    assign hreadyout = hreadyout_ff;
    assign hresp = hresp_ff;
    assign hrdata = hrdata_ff;
    assign sys_rsp = rsp_ff;
    assign core_reset = core_reset_ff;
    assign dma_sub_reset = dma_sub_ff;
    assign dma_mod_reset = dma_mod_ff;
    assign irq = irq_ff;

    // checks beside the logic

    a_watch_expiry: assert property ( // see [R3]
        @(posedge ref_clk) disable iff (!rst_n)
        (st_ff == W_WAIT && ~acked && cnt_ff == last_cnt)
        |=> (sys_rsp.data_abort && sys_rsp.cycle_end && st_ff == W_IDLE))
        else $error("timeout did not abort");

    a_watch_period: assert property ( // see [R1]
        @(posedge ref_clk) disable iff (!rst_n)
        (st_ff == W_WAIT) |-> (cnt_ff < period))
        else $error("watch count passed period");

    a_count_step: assert property ( // see [R16]
        @(posedge ref_clk) disable iff (!rst_n)
        (st_ff == W_IDLE && watch_go) ##1 (transfer_ack_n && cnt_ff != last_cnt)
        |=> (cnt_ff == $past(cnt_ff) + 8'h01))
        else $error("watch count did not step");

    a_user_refuse: assert property ( // see [R4]
        @(posedge ref_clk) disable iff (!rst_n)
        (sys_req.start && sys_req.user && sys_req.int_reg && !user_ok)
        |=> sys_rsp.data_abort ##1 stat_ff[`EV_USER])
        else $error("user access not refused");

    a_user_allow: assert property ( // see [R5]
        @(posedge ref_clk) disable iff (!rst_n)
        (sys_req.start && user_ok && !unal_abort && st_ff == W_IDLE)
        |=> !sys_rsp.data_abort)
        else $error("allowed access aborted");

    a_unalign_abort: assert property ( // see [R11]
        @(posedge ref_clk) disable iff (!rst_n)
        (sys_req.start && sys_req.size == `SZ_WORD
         && sys_req.addr_lo != 2'h0)
        |=> (sys_rsp.data_abort == ($past(unalign_en)
             || $past(user_abort) || $past(expire))))
        else $error("misaligned word abort wrong");

    a_strap_load: assert property ( // see [R6]
        @(posedge ref_clk) disable iff (!rst_n)
        (rst_n && !strap_done_ff)
        |=> (ctl_ff[`B_STRAP] == !$past(boot_strap_line)
        && core_reset == !$past(boot_strap_line)))
        else $error("strap not captured");

    a_dma_resets: assert property ( // see [R8]
        @(posedge ref_clk) disable iff (!rst_n)
        ##1 (dma_sub_reset == ctl_ff[`B_DIAG]
             && dma_mod_reset == ctl_ff[`B_DMA_SOFT_RESET]))
        else $error("dma reset mismatch");

    a_reserved_zero: assert property ( // see [R17]
        @(posedge ref_clk) disable iff (!rst_n)
        $past(addr_ph && !hwrite && a_lo == `OFS_SYSCTL)
        |-> (hrdata[13] == 1'b0 && hrdata[9:8] == 2'h0))
        else $error("reserved bits read nonzero");

    a_ctx_grant: assert property ( // see [R8]
        @(posedge ref_clk) disable iff (!rst_n)
        (sys_req.start && sys_req.dma_ctx && diag) |=> sys_rsp.ctx_grant)
        else $error("context memory not opened");

    a_ctx_closed: assert property ( // see [R9]
        @(posedge ref_clk) disable iff (!rst_n)
        (!sys_req.start || !diag) |=> !sys_rsp.ctx_grant)
        else $error("context memory opened outside diag");

    a_core_hold: assert property ( // see [R13]
        @(posedge ref_clk) disable iff (!rst_n)
        (rst_n && strap_done_ff) |-> (core_reset == ctl_ff[`B_HOLD]))
        else $error("core reset does not follow hold bit");

    a_legacy_store: assert property ( // see [R10]
        @(posedge ref_clk) disable iff (!rst_n)
        wr_ctl |=> (ctl_ff[`B_LEGACY] == $past(hwdata[`B_LEGACY])))
        else $error("legacy bit not stored");

    a_set_wins: assert property ( // see [R3]
        @(posedge ref_clk) disable iff (!rst_n)
        (wr_clr && |evt) |=> ((stat_ff & $past(evt)) == $past(evt)))
        else $error("event lost to a same-cycle clear");

    a_irq_level: assert property ( // see [R3]
        @(posedge ref_clk) disable iff (!rst_n)
        strap_done_ff |-> (irq == |(stat_ff & en_ff)))
        else $error("irq does not match enabled status");

    a_bus_okay: assert property ( // see [R17]
        @(posedge ref_clk) disable iff (!rst_n)
        strap_done_ff |-> (hreadyout && !hresp))
        else $error("bus slave stalled or erred");

    a_refused_idle: assert property ( // see [R16]
        @(posedge ref_clk) disable iff (!rst_n)
        (st_ff == W_IDLE && refused) |=> (st_ff == W_IDLE))
        else $error("refused cycle was monitored");

endmodule // system_control_guard

// ==== sys_master_model.sv ====
`timescale 1ns/10ps
// stands in for the core and other masters on the system bus
module sys_master_model
    import sysctl_pkg::*;
(
    input wire logic ref_clk,
    input wire sys_rsp_t sys_rsp,
    output sys_req_t sys_req,
    output logic transfer_ack_n
);
    // clocks after start at which grant and cycle end were first seen
    int gnt_at = 0;
    int end_at = 0;

    initial begin
        sys_req = '0;
        transfer_ack_n = 1'b1;
    end

    // one bus cycle; ack after ack_at clocks (0 = never acknowledged)
    // sa[4] asks for context memory, sa[3:2] size, sa[1:0] address
    task automatic run(input logic u, input logic [4:0] sa, input int ack_at,
        output int lat);
        lat = 0;
        gnt_at = 0;
        end_at = 0;
        @(posedge ref_clk);
        sys_req <= '{1'b1, u, 1'b1, sa[4], sa[3:2], sa[1:0]};
        @(posedge ref_clk);
        // stale fields are scrambled so they never look like a valid cycle
        sys_req <= '{1'b0, ~u, 1'b0, ~sa[4], ~sa[3:2], ~sa[1:0]};
        for (int n = 1; n < 140; n++) begin
            @(posedge ref_clk);
            transfer_ack_n <= (n != ack_at);
            if (sys_rsp.data_abort === 1'b1 && lat == 0) lat = n;
            if (sys_rsp.ctx_grant === 1'b1 && gnt_at == 0) gnt_at = n;
            if (sys_rsp.cycle_end === 1'b1 && end_at == 0) end_at = n;
        end
    endtask
endmodule // sys_master_model

// ==== tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
    import sysctl_pkg::*;
    logic ref_clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic core_reset, dma_sub_reset, dma_mod_reset;
    logic boot_strap_line, transfer_ack_n;
    logic rd_ph_ff = 1'b0;
    sys_req_t sys_req;
    sys_rsp_t sys_rsp;
    logic [31:0] q[$];
    logic [31:0] rnd = 32'h0000_fa6f;
    int err_count = 0;
    int comparisons = 0;
    int cyc = 0;

    assign hready = hreadyout;
    system_control_guard dut_u(.ref_clk, .rst_n, .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
        .sys_req, .transfer_ack_n, .boot_strap_line, .sys_rsp, .core_reset,
        .dma_sub_reset, .dma_mod_reset, .irq);
    sys_master_model sys_u(.ref_clk, .sys_rsp, .sys_req, .transfer_ack_n);

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic check(input string nm, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task tally_and_finish;
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    // single word transfer; waits on hready, never on a fixed count
    task automatic ahb(input logic w, input logic [31:0] a, d);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge ref_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hready !== 1'b1);
    endtask

    task automatic rd(input logic [31:0] a, e);
        q.push_back(e);
        ahb(1'b0, a, 32'h0000_0000);
    endtask

    // read results checked in the data phase against the oldest note
    always @(posedge ref_clk) begin
        if (rd_ph_ff && hready) begin
            check("hrdata", hrdata, q.pop_front());
            check("hresp", hresp, 0);
        end
        rd_ph_ff <= hsel & hready & htrans[1] & ~hwrite;
        cyc++;
        if (cyc > 20000) begin
            err_count++;
            tally_and_finish();
        end
    end

    initial begin
        logic [31:0] d;
        logic [4:0] ut[5];
        int lat;
        ut = '{5'h05, 5'h0a, 5'h09, 5'h06, 5'h08};
        {rst_n, hsel, hwrite, htrans, haddr, hwdata} = '0;
        boot_strap_line = 1'b0;
        hsize = 3'h2;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(32'h0000_0000, 32'h0000_4080);
        check("core_reset", core_reset, 1);
        // the clear register is write-only and reads back zero
        rd(32'h0000_0008, 32'h0000_0000);
        // strap bit always written 0 by software
        for (int i = 0; i < 4; i++) begin
            rnd = xs(rnd);
            d = (i == 0) ? 32'hffff_bfff : rnd & ~32'h0000_4000;
            ahb(1'b1, 32'h0000_0000, d);
            rd(32'h0000_0000, d & 32'h0007_9cc0);
        end
        ahb(1'b1, 32'h0000_0000, 32'h0000_18c0);
        repeat (2) @(posedge ref_clk);
        check("dma_sub", dma_sub_reset, 1);
        check("dma_mod", dma_mod_reset, 1);
        check("core", core_reset, 1);
        sys_u.run(1'b0, 5'h18, 3, lat);
        check("ctx_open", sys_u.gnt_at, 1);
        ahb(1'b1, 32'h0000_0000, 32'h0000_0000);
        repeat (2) @(posedge ref_clk);
        d = {29'h0, core_reset, dma_sub_reset, dma_mod_reset};
        check("outs", d, 0);
        sys_u.run(1'b0, 5'h18, 3, lat);
        check("ctx_shut", sys_u.gnt_at, 0);
        sys_u.run(1'b1, 5'h08, 0, lat);
        check("user_gate", lat, 1);
        ahb(1'b1, 32'h0000_0000, 32'h0000_8400);
        sys_u.run(1'b1, 5'h08, 3, lat);
        check("user_ok", lat, 0);
        for (int i = 0; i < 5; i++) begin
            sys_u.run(1'b0, ut[i], 3, lat);
            check("unaligned", lat, (i < 3));
        end
        ahb(1'b1, 32'h0000_0000, 32'h0000_8000);
        sys_u.run(1'b0, 5'h05, 3, lat);
        check("unalign_off", lat, 0);
        // every limit code; these cycles are never acknowledged, so each one times out
        for (int c = 0; c < 4; c++) begin
            ahb(1'b1, 32'h0000_0000, 32'h0004_8000 | (c << 16));
            sys_u.run(1'b0, 5'h08, 0, lat);
            check("watch", lat, (128 >> c) + 1);
            check("cycle_end", sys_u.end_at, (128 >> c) + 1);
        end
        sys_u.run(1'b0, 5'h08, 5, lat);
        check("acked", lat, 0);
        check("no_end", sys_u.end_at, 0);
        sys_u.run(1'b0, 5'h08, 0, lat);
        check("restart", lat, 17);
        rd(32'h0000_0004, 32'h0000_0007);
        check("irq_masked", irq, 0);
        ahb(1'b1, 32'h0000_000c, 32'h0000_0001);
        repeat (2) @(posedge ref_clk);
        check("irq_on", irq, 1);
        ahb(1'b1, 32'h0000_0008, 32'h0000_0007);
        rd(32'h0000_0004, 32'h0000_0000);
        check("irq_off", irq, 0);
        rst_n <= 1'b0;
        boot_strap_line <= 1'b1;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(32'h0000_0000, 32'h0000_0000);
        check("core_run", core_reset, 0);
        tally_and_finish();
    end
endmodule // tb_top
